// >>> src/tldc_top.sv
// Purpose: Transmit line driver float, over-current, power-down and clock-loss control.
// Assumes: Pins are asynchronous and pass two flip-flops; rst is synchronous, active high.
// Notes:   Each data output comes from a flip-flop; interrupt is a combinational level.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module tldc_top
  import tldc_pkg::*;
#(
  parameter int N_CH          = 4,
  parameter int RECOVER_CYC   = RECOVER_CYC_DEF,
  parameter int MCLK_LOSS_CYC = MCLK_LOSS_CYC_DEF
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [11:0]     avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic            output_enable_in,
  input  wire logic            mclk_in,
  input  wire logic [N_CH-1:0] tx_clock_in,
  input  wire logic [N_CH-1:0] tx_serial_data_in,
  input  wire logic [N_CH-1:0] tx_positive_rail_in,
  input  wire logic [N_CH-1:0] tx_negative_rail_in,
  input  wire logic [N_CH-1:0] transmit_overcurrent,
  output logic      [N_CH-1:0] line_tip_out,
  output logic      [N_CH-1:0] line_tip_oe,
  output logic      [N_CH-1:0] line_ring_out,
  output logic      [N_CH-1:0] line_ring_oe,
  output logic      [N_CH-1:0] current_limit_out,
  output logic      [N_CH-1:0] tx_multifunction_out,
  output logic      [N_CH-1:0] tx_multifunction_oe,
  output logic                 line_rate_ref_clock,
  output logic                 irq_n
);

  // Elaboration-time check of parameter ranges.
  if (N_CH < 1 || N_CH > 64 || RECOVER_CYC < 1 || RECOVER_CYC > 131071 ||
      MCLK_LOSS_CYC < 1 || MCLK_LOSS_CYC > 131071) begin : g_bad_param
    $error("tldc_top parameter out of range");
  end

  localparam int SW = 5 * N_CH + 2;

  logic [SW-1:0]  sync1;
  logic [SW-1:0]  sync2;
  logic           oe_pin_s;
  logic           mclk_s;
  logic           mclk_d;
  logic [N_CH-1:0] tclk_s, tclk_d, sdat_s, pdat_s, ndat_s, oc_s, oc_d;
  logic           ack;
  logic           wr_en;
  logic           rd_take;
  logic           gsoft;
  logic [4:0]     glb_ctrl;
  logic [16:0]    mclk_cnt;
  logic           mclk_lost;
  logic [31:0]    ref_acc;
  logic [32:0]    next_ref_acc;
  logic           fmt_nrz;
  logic           tclk_exempt;
  logic [31:0]    next_rdata;
  tldc_tx_cfg_t   tx_cfg [N_CH];
  logic [N_CH-1:0] tmf_oc_sel, edge_sel, flag, mask, channel_soft_reset_pulse, tclk_lost, hiz_cause;
  tldc_pd_state_t pd_state [N_CH];
  logic [16:0]    wake_cnt [N_CH];
  logic [6:0]     tclk_cnt [N_CH];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Channel index of a per-channel address, or N_CH when none matches.
  function automatic int ch_of(input logic [11:0] a);
    if (a[11] || (int'(a[10:5]) >= N_CH)) begin
      return N_CH;
    end
    return int'(a[10:5]);
  endfunction

  // Two-stage synchroniser for every asynchronous pin.
  always_ff @(posedge clk) begin
    sync1 <= {output_enable_in, mclk_in, tx_clock_in, tx_serial_data_in,
              tx_positive_rail_in, tx_negative_rail_in, transmit_overcurrent};
    sync2 <= sync1;
  end

  assign {oe_pin_s, mclk_s, tclk_s, sdat_s, pdat_s, ndat_s, oc_s} = sync2;

  // Edge-detect history for synchronised clocks and over-current.
  always_ff @(posedge clk) begin
    if (rst) begin
      mclk_d <= 1'b0;
      tclk_d <= '0;
      oc_d   <= '0;
    end else begin
      mclk_d <= mclk_s;
      tclk_d <= tclk_s;
      oc_d   <= oc_s;
    end
  end

  // Every access waits one cycle; the write lands and read data stands at the second edge.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_en           = avs_write & ack;
  assign rd_take         = avs_read & ~ack;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Global control word and the self-clearing global soft reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      glb_ctrl <= GLB_CTRL_RST;
      gsoft    <= 1'b0;
    end else begin
      gsoft <= wr_en && (avs_address == ADDR_GLB_RST);
      if (gsoft) begin
        glb_ctrl <= GLB_CTRL_RST;
      end else if (wr_en && avs_address == ADDR_GLB_CTRL) begin
        glb_ctrl <= avs_writedata[4:0];
      end
    end
  end

  assign fmt_nrz     = (glb_ctrl[BIT_G_FMT +: 2] == FMT_SINGLE_NRZ) ||
                       (glb_ctrl[BIT_G_FMT +: 2] == FMT_DUAL_NRZ);
  assign tclk_exempt = glb_ctrl[BIT_G_RLB] | glb_ctrl[BIT_G_PATREF];

  // Line-rate reference tick from a phase accumulator.
  assign next_ref_acc = {1'b0, ref_acc} + {1'b0, glb_ctrl[BIT_G_E1] ? REF_INC_E1 : REF_INC_T1};

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_acc             <= '0;
      line_rate_ref_clock <= 1'b0;
    end else begin
      ref_acc             <= next_ref_acc[31:0];
      line_rate_ref_clock <= next_ref_acc[32];
    end
  end

  // Master clock watchdog; a stopped master clock floats every channel.
  always_ff @(posedge clk) begin
    if (rst) begin
      mclk_cnt  <= '0;
      mclk_lost <= 1'b0;
    end else if (mclk_s != mclk_d) begin
      mclk_cnt  <= '0;
      mclk_lost <= 1'b0;
    end else if (int'(mclk_cnt) >= MCLK_LOSS_CYC) begin
      mclk_lost <= 1'b1;
    end else begin
      mclk_cnt <= mclk_cnt + 17'h00001;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    int c;
    c = ch_of(avs_address);
    next_rdata = 32'h0;
    if (avs_address == ADDR_GLB_CTRL) begin
      next_rdata[4:0] = glb_ctrl;
    end else if (avs_address == ADDR_GLB_STAT) begin
      next_rdata[0] = mclk_lost;
    end else if (c < N_CH) begin
      case (avs_address[4:0])
        OFF_TX_CONFIG: next_rdata[6:0] = tx_cfg[c];
        OFF_CH_CONFIG: next_rdata[BIT_TMF_OC] = tmf_oc_sel[c];
        OFF_STATUS: begin
          next_rdata[BIT_OC]       = oc_d[c];
          next_rdata[BIT_ST_TCLKL] = tclk_lost[c];
          next_rdata[BIT_ST_READY] = (pd_state[c] == PD_ON);
        end
        OFF_IRQ_EDGE: next_rdata[BIT_OC] = edge_sel[c];
        OFF_IRQ_FLAG: next_rdata[BIT_OC] = flag[c];
        OFF_IRQ_MASK: next_rdata[BIT_OC] = mask[c];
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (rd_take) begin
      avs_readdata <= next_rdata;
    end
  end

  // Shared interrupt pin, low while an unmasked flag stands.
  assign irq_n = ~|(flag & ~mask);

  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    logic ch_wr;
    logic ch_rst;
    logic oc_set;
    logic oc_clr;
    logic tx_active;

    assign ch_wr     = wr_en && (ch_of(avs_address) == g);
    assign ch_rst    = gsoft | channel_soft_reset_pulse[g];
    assign tx_active = (pd_state[g] == PD_ON);

    // Configuration registers of this channel.
    always_ff @(posedge clk) begin
      if (rst || ch_rst) begin
        tx_cfg[g]     <= TX_CONFIG_RST;
        tmf_oc_sel[g] <= 1'b0;
        edge_sel[g]   <= 1'b0;
        mask[g]       <= MASK_RST;
      end else if (ch_wr) begin
        case (avs_address[4:0])
          OFF_TX_CONFIG: tx_cfg[g]     <= avs_writedata[6:0];
          OFF_CH_CONFIG: tmf_oc_sel[g] <= avs_writedata[BIT_TMF_OC];
          OFF_IRQ_EDGE:  edge_sel[g]   <= avs_writedata[BIT_OC];
          OFF_IRQ_MASK:  mask[g]       <= avs_writedata[BIT_OC];
          default:       tx_cfg[g]     <= tx_cfg[g];
        endcase
      end
    end

    // Soft reset of this channel, a one-cycle pulse from a write of one.
    always_ff @(posedge clk) begin
      if (rst) begin
        channel_soft_reset_pulse[g] <= 1'b0;
      end else begin
        channel_soft_reset_pulse[g] <= ch_wr && avs_address[4:0] == OFF_CH_CONFIG &&
                          avs_writedata[BIT_CHANNEL_SOFT_RESET];
      end
    end

    // Over-current flag; a new edge wins over a clear in the same cycle.
    assign oc_set = (oc_s[g] & ~oc_d[g]) | (edge_sel[g] & ~oc_s[g] & oc_d[g]);
    assign oc_clr = ch_wr && avs_address[4:0] == OFF_IRQ_FLAG && avs_writedata[BIT_OC];

    always_ff @(posedge clk) begin
      if (rst || ch_rst) begin
        flag[g] <= 1'b0;
      end else begin
        flag[g] <= oc_set | (flag[g] & ~oc_clr);
      end
    end

    // Power-down sequence with a settling wait after the bit clears.
    always_ff @(posedge clk) begin
      if (rst || ch_rst) begin
        pd_state[g] <= PD_ON;
        wake_cnt[g] <= '0;
      end else begin
        case (pd_state[g])
          PD_ON: begin
            if (tx_cfg[g].power_down) begin
              pd_state[g] <= PD_OFF;
            end
          end
          PD_OFF: begin
            wake_cnt[g] <= '0;
            if (!tx_cfg[g].power_down) begin
              pd_state[g] <= PD_WAKE;
            end
          end
          PD_WAKE: begin
            if (tx_cfg[g].power_down) begin
              pd_state[g] <= PD_OFF;
            end else if (int'(wake_cnt[g]) >= RECOVER_CYC - 1) begin
              pd_state[g] <= PD_ON;
            end else begin
              wake_cnt[g] <= wake_cnt[g] + 17'h00001;
            end
          end
          default: pd_state[g] <= PD_OFF;
        endcase
      end
    end

    // Transmit clock watchdog counted in reference ticks, NRZ formats only.
    always_ff @(posedge clk) begin
      if (rst || ch_rst || !fmt_nrz || tclk_exempt || !tx_active ||
          (tclk_s[g] != tclk_d[g])) begin
        tclk_cnt[g] <= '0;
      end else if (line_rate_ref_clock && int'(tclk_cnt[g]) <= TCLK_LOSS_REF) begin
        tclk_cnt[g] <= tclk_cnt[g] + 7'h01;
      end
    end

    assign tclk_lost[g] = int'(tclk_cnt[g]) > TCLK_LOSS_REF;

    // Every float cause of this channel gathered in one term.
    assign hiz_cause[g] = ~oe_pin_s | mclk_lost | gsoft | ~tx_cfg[g].drv_en | ~tx_active |
                          channel_soft_reset_pulse[g] | tclk_lost[g] |
                          (oc_d[g] & tx_cfg[g].float_select);

    // Line driver outputs; enables fall in the cycle after a cause appears.
    always_ff @(posedge clk) begin
      if (rst) begin
        line_tip_oe[g]       <= 1'b0;
        line_ring_oe[g]      <= 1'b0;
        line_tip_out[g]      <= 1'b0;
        line_ring_out[g]     <= 1'b0;
        current_limit_out[g] <= 1'b0;
      end else begin
        line_tip_oe[g]       <= ~hiz_cause[g];
        line_ring_oe[g]      <= ~hiz_cause[g] & ~tx_cfg[g].single_ended;
        line_tip_out[g]      <= tx_active & ((glb_ctrl[BIT_G_FMT +: 2] == FMT_SINGLE_NRZ) ?
                                sdat_s[g] : pdat_s[g]);
        line_ring_out[g]     <= tx_active & (glb_ctrl[BIT_G_FMT +: 2] != FMT_SINGLE_NRZ) &
                                ndat_s[g];
        current_limit_out[g] <= oc_d[g] & ~tx_cfg[g].float_select & ~hiz_cause[g];
      end
    end

    // Multifunction output shows live over-current and floats in power-down.
    always_ff @(posedge clk) begin
      if (rst) begin
        tx_multifunction_out[g] <= 1'b0;
        tx_multifunction_oe[g]  <= 1'b0;
      end else begin
        tx_multifunction_out[g] <= tmf_oc_sel[g] & oc_d[g];
        tx_multifunction_oe[g]  <= ~tx_cfg[g].power_down & (pd_state[g] != PD_OFF);
      end
    end

    a_float_any_cause: assert property (hiz_cause[g] |=> !line_tip_oe[g] && !line_ring_oe[g])
      else $error("outputs driven while a float cause stood");
    a_drive_no_cause: assert property (!hiz_cause[g] |=> line_tip_oe[g])
      else $error("tip floated with no cause");
    a_oe_pin_float: assert property (!oe_pin_s |=> !line_tip_oe[g])
      else $error("global enable low left tip driven");
    a_single_ring_off: assert property (tx_cfg[g].single_ended |=> !line_ring_oe[g])
      else $error("ring driven in single-ended mode");
    a_oc_limit_on: assert property (oc_d[g] && !tx_cfg[g].float_select && !hiz_cause[g]
                                    |=> current_limit_out[g])
      else $error("over-current not limited");
    a_oc_rise_flag: assert property ($rose(oc_s[g]) && !ch_rst |=> flag[g] ##1
                                     (flag[g] || $past(oc_clr) || $past(ch_rst)))
      else $error("over-current rise did not set flag");
    a_oc_fall_edge: assert property ($fell(oc_s[g]) && !edge_sel[g] && !flag[g]
                                     && !ch_rst |=> !flag[g])
      else $error("falling edge set flag in rise-only mode");
    a_pd_float_all: assert property ($rose(tx_cfg[g].power_down)
                                     |-> ##[1:2] !line_tip_oe[g] && !tx_multifunction_oe[g])
      else $error("power-down left outputs driven");
    a_wake_bounded: assert property (pd_state[g] == PD_WAKE |-> int'(wake_cnt[g]) < RECOVER_CYC)
      else $error("recovery exceeded its time");
    a_tclk_loss_float: assert property (tclk_lost[g] |=> !line_tip_oe[g] && !line_ring_oe[g])
      else $error("lost transmit clock left outputs driven");
    a_channel_soft_reset_float: assert property (channel_soft_reset_pulse[g] |=> !line_tip_oe[g] && tx_cfg[g] == TX_CONFIG_RST)
      else $error("channel reset did not float and clear");
  end

  a_irq_level: assert property (|(flag & ~mask) |-> !irq_n)
    else $error("unmasked flag without interrupt");
  a_mclk_loss_float: assert property (mclk_lost |=> line_tip_oe == '0)
    else $error("master clock loss left outputs driven");
  a_ref_tick_pulse: assert property (line_rate_ref_clock |=> !line_rate_ref_clock)
    else $error("reference tick longer than one cycle");

endmodule // tldc_top
`default_nettype wire

// >>> src/tldc_pkg.sv
// Purpose: Shared constants and types for the transmit line driver control block.
// Assumes: 100 MHz system clock, 32-bit Avalon-MM register bus with byte addresses.
// Notes:   Channel registers repeat at a fixed stride; globals sit in a high window.
// Behaviour
// - Global output-enable pin low floats every channel's tip and ring.
// - Per-channel driver-enable bit b6 at zero floats that channel's outputs.
// - Either enable floats tip and ring immediately; other channel logic keeps running.
// - Over-current limits current when b4 is zero, floats outputs when b4 is one.
// - Live over-current status; flag set on rising edge or any edge per b4.
// - Unmasked over-current flag drives the shared active-low interrupt pin.
// - Multifunction output can be configured to show over-current.
// - Single-ended bit b3: differential drives tip and ring, single-ended tip only.
// - Differential T1/J1 uses internal matching only; E1 allows internal or external. The code stores any term code in either mode.
// - Power-down bit b5 floats tip, ring and multifunction, ignores data and clock.
// - After power-down clears, transmitter returns to previous setup within 1 ms.
// - No master clock transition for over 1 ms floats all channels.
// - All outputs float during reset; external reset pin held over 2 us.
// - NRZ formats: transmit clock idle over 64 reference cycles floats that channel.
// - Writing one to soft-reset bit b1 resets channel and floats its outputs.
// - Reference clock is 1.544 MHz in T1/J1 mode, 2.048 MHz in E1 mode.
package tldc_pkg;

  // Clock and timing.
  localparam longint CLK_HZ          = 100000000;
  localparam int     CLK_PERIOD_NS   = 10;
  localparam int     RECOVER_TIME_NS = 1000000;
  localparam int     MCLK_LOSS_NS    = 1000000;
  localparam int     RECOVER_CYC_DEF = RECOVER_TIME_NS / CLK_PERIOD_NS;
  localparam int     MCLK_LOSS_CYC_DEF = MCLK_LOSS_NS / CLK_PERIOD_NS;
  localparam int     TCLK_LOSS_REF   = 64;
  localparam longint REF_T1_HZ       = 1544000;
  localparam longint REF_E1_HZ       = 2048000;
  localparam logic [31:0] REF_INC_T1 = 32'((REF_T1_HZ << 32) / CLK_HZ);
  localparam logic [31:0] REF_INC_E1 = 32'((REF_E1_HZ << 32) / CLK_HZ);

  // Register map, byte addresses.
  localparam logic [11:0] CH_STRIDE      = 12'h020;
  localparam logic [4:0]  OFF_TX_CONFIG  = 5'h00;
  localparam logic [4:0]  OFF_CH_CONFIG  = 5'h04;
  localparam logic [4:0]  OFF_STATUS     = 5'h08;
  localparam logic [4:0]  OFF_IRQ_EDGE   = 5'h0c;
  localparam logic [4:0]  OFF_IRQ_FLAG   = 5'h10;
  localparam logic [4:0]  OFF_IRQ_MASK   = 5'h14;
  localparam logic [11:0] ADDR_GLB_CTRL  = 12'h800;
  localparam logic [11:0] ADDR_GLB_RST   = 12'h804;
  localparam logic [11:0] ADDR_GLB_STAT  = 12'h808;

  // Field positions.
  localparam int BIT_OC        = 4;
  localparam int BIT_CHANNEL_SOFT_RESET     = 1;
  localparam int BIT_TMF_OC    = 0;
  localparam int BIT_ST_TCLKL  = 1;
  localparam int BIT_ST_READY  = 0;
  localparam int BIT_G_E1      = 0;
  localparam int BIT_G_FMT     = 1;
  localparam int BIT_G_RLB     = 3;
  localparam int BIT_G_PATREF  = 4;

  // Transmit system formats.
  localparam logic [1:0] FMT_SINGLE_NRZ = 2'h0;
  localparam logic [1:0] FMT_DUAL_NRZ   = 2'h1;
  localparam logic [1:0] FMT_DUAL_RZ    = 2'h2;

  // Reset values.
  localparam logic [6:0] TX_CONFIG_RST = 7'h40;
  localparam logic       MASK_RST      = 1'b1;
  localparam logic [4:0] GLB_CTRL_RST  = 5'h00;

  // Transmit configuration word, bits 6 down to 0.
  typedef struct packed {
    logic       drv_en;
    logic       power_down;
    logic       float_select;
    logic       single_ended;
    logic [2:0] term;
  } tldc_tx_cfg_t;

  // Power-down sequence states; one bit changes on each step except PD_WAKE to PD_ON.
  typedef enum logic [1:0] {
    PD_ON   = 2'b00,
    PD_OFF  = 2'b01,
    PD_WAKE = 2'b11
  } tldc_pd_state_t;

endpackage

// >>> verification/tldc_line_model.sv
// Purpose: Line-side model of the transformer-coupled pair with its over-current sensor.
// Assumes: One clock; the bench decides when the pair is shorted.
// Notes:   The sensor answers after one cycle, or after four when slow is high.
`timescale 1ns/1ns
`default_nettype none
module tldc_line_model #(
  parameter int N_CH = 4
) (
  input  wire logic            clk,
  input  wire logic            slow,
  input  wire logic [N_CH-1:0] short_cmd,
  input  wire logic [N_CH-1:0] tip_oe,
  input  wire logic [N_CH-1:0] ring_oe,
  output logic      [N_CH-1:0] line_driven,
  output logic      [N_CH-1:0] transmit_overcurrent
);
  logic [N_CH-1:0] stage [4];

  // A short stays on the pair while the driver floats, so the sensor keeps reporting it.
  always_ff @(posedge clk) begin
    stage[0] <= short_cmd;
    for (int i = 1; i < 4; i++) begin
      stage[i] <= stage[i-1];
    end
  end

  // Sensor output, prompt or slow.
  assign transmit_overcurrent = slow ? stage[3] : stage[0];
  // The pair carries signal while either leg is driven.
  assign line_driven = tip_oe | ring_oe;
endmodule // tldc_line_model
`default_nettype wire

// >>> verification/test_tx_line_driver_control.sv
// Purpose: Self-checking bench for the transmit line driver control block.
// Assumes: 100 MHz clock; shortened recovery and master clock loss counts.
// Notes:   Register accesses hold until waitrequest is seen low at a rising edge.
`timescale 1ns/1ns
`default_nettype none
module test_tx_line_driver_control
  import tldc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        output_enable_in = 1'b1;
  logic        mclk_in = 1'b0;
  logic        mclk_run = 1'b1;
  logic        slow = 1'b0;
  logic [3:0]  tclk_run = 4'hf;
  logic [3:0]  short_cmd = 4'h0;
  logic [3:0]  tx_clock_in = 4'h0;
  logic [3:0]  tx_serial_data_in = 4'h0;
  logic [3:0]  tx_positive_rail_in = 4'h0;
  logic [3:0]  tx_negative_rail_in = 4'h0;
  logic [3:0]  transmit_overcurrent;
  logic [3:0]  line_tip_out, line_tip_oe, line_ring_out, line_ring_oe;
  logic [3:0]  current_limit_out, tx_multifunction_out, tx_multifunction_oe;
  logic        line_rate_ref_clock;
  logic        irq_n;
  logic [7:0]  tick = 8'h00;
  logic [31:0] q;
  int          refcnt = 0;
  int          c0;
  int          bad_count = 0;
  int          checks_done = 0;

  tldc_top #(.N_CH(4), .RECOVER_CYC(20), .MCLK_LOSS_CYC(50)) i_tldc_top (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .output_enable_in(output_enable_in),
    .mclk_in(mclk_in), .tx_clock_in(tx_clock_in), .tx_serial_data_in(tx_serial_data_in),
    .tx_positive_rail_in(tx_positive_rail_in), .tx_negative_rail_in(tx_negative_rail_in),
    .transmit_overcurrent(transmit_overcurrent), .line_tip_out(line_tip_out),
    .line_tip_oe(line_tip_oe), .line_ring_out(line_ring_out), .line_ring_oe(line_ring_oe),
    .current_limit_out(current_limit_out), .tx_multifunction_out(tx_multifunction_out),
    .tx_multifunction_oe(tx_multifunction_oe), .line_rate_ref_clock(line_rate_ref_clock),
    .irq_n(irq_n));

  tldc_line_model #(.N_CH(4)) i_tldc_line_model (
    .clk(clk), .slow(slow), .short_cmd(short_cmd), .tip_oe(line_tip_oe),
    .ring_oe(line_ring_oe), .line_driven(), .transmit_overcurrent(transmit_overcurrent));

  // Clock of 10 ns period.
  initial begin
    forever #5 clk = ~clk;
  end

  // System-side pins: master clock, transmit clocks toggled every 8 cycles, moving data, pulse count.
  always @(posedge clk) begin
    tick <= tick + 8'h01;
    if (mclk_run) mclk_in <= ~mclk_in;
    if (tick[2:0] == 3'h7) tx_clock_in <= tx_clock_in ^ tclk_run;
    tx_serial_data_in <= tick[3:0];
    tx_positive_rail_in <= tick[4:1];
    tx_negative_rail_in <= ~tick[4:1];
    if (line_rate_ref_clock === 1'b1) refcnt <= refcnt + 1;
  end

  function automatic logic [11:0] ca(input int c, input logic [4:0] off);
    return 12'(c) * CH_STRIDE + 12'(off);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One Avalon access; read data are taken at the edge where waitrequest is low.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) bad_count++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d bad=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected length of the run.
  initial begin
    cyc(60000);
    bad_count++;
    summarize();
  end

  // Test sequence.
  initial begin
    cyc(6);
    check(32'(line_tip_oe | line_ring_oe), 32'h0);
    rst <= 1'b0;
    rd(ca(0, OFF_TX_CONFIG)); check(q, 32'(TX_CONFIG_RST));
    rd(ca(0, OFF_IRQ_MASK)); check(q, 32'h10);
    rd(12'h7fc); check(q, 32'h0);
    cyc(10);
    check(32'(line_tip_oe & line_ring_oe), 32'hf);
    output_enable_in <= 1'b0; cyc(6);
    check(32'(line_tip_oe | line_ring_oe), 32'h0);
    output_enable_in <= 1'b1; cyc(6);
    wr(ca(1, OFF_TX_CONFIG), 32'h0); cyc(4);
    check(32'(line_tip_oe), 32'hd);
    wr(ca(1, OFF_TX_CONFIG), 32'h40);
    // Coax setup: single-ended with the coaxial termination code.
    wr(ca(0, OFF_TX_CONFIG), 32'h4b); cyc(4);
    check(32'({line_tip_oe[0], line_ring_oe[0]}), 32'h2);
    rd(ca(0, OFF_TX_CONFIG)); check(q, 32'h4b);
    // Differential, line rate left at T1, with the external matching code.
    wr(ca(0, OFF_TX_CONFIG), 32'h47);
    rd(ca(0, OFF_TX_CONFIG)); check(q, 32'h47);
    // Over-current with limiting, indication, interrupt and its mask.
    wr(ca(0, OFF_IRQ_MASK), 32'h0);
    wr(ca(0, OFF_CH_CONFIG), 32'h1);
    short_cmd <= 4'h1; cyc(8);
    rd(ca(0, OFF_STATUS)); check(q & 32'h10, 32'h10);
    rd(ca(0, OFF_IRQ_FLAG)); check(q, 32'h10);
    check(32'({irq_n, current_limit_out[0], line_tip_oe[0], tx_multifunction_out[0]}), 32'h7);
    wr(ca(0, OFF_IRQ_MASK), 32'h10); cyc(1);
    check(32'(irq_n), 32'h1);
    wr(ca(0, OFF_IRQ_MASK), 32'h0);
    wr(ca(0, OFF_IRQ_FLAG), 32'h10); cyc(1);
    check(32'(irq_n), 32'h1);
    short_cmd <= 4'h0; cyc(8);
    rd(ca(0, OFF_IRQ_FLAG)); check(q, 32'h0);
    wr(ca(0, OFF_IRQ_EDGE), 32'h10);
    short_cmd <= 4'h1; cyc(8);
    wr(ca(0, OFF_IRQ_FLAG), 32'h10);
    short_cmd <= 4'h0; cyc(8);
    rd(ca(0, OFF_IRQ_FLAG)); check(q, 32'h10);
    wr(ca(0, OFF_IRQ_EDGE), 32'h0);
    // Float on over-current, with a slow sensor.
    slow <= 1'b1;
    wr(ca(0, OFF_TX_CONFIG), 32'h50);
    short_cmd <= 4'h1; cyc(12);
    check(32'({line_tip_oe[0], line_ring_oe[0]}), 32'h0);
    short_cmd <= 4'h0; cyc(12);
    check(32'({line_tip_oe[0], line_ring_oe[0]}), 32'h3);
    wr(ca(0, OFF_TX_CONFIG), 32'h40);
    wr(ca(0, OFF_IRQ_FLAG), 32'h10);
    wr(ca(0, OFF_IRQ_MASK), 32'h10);
    wr(ca(0, OFF_CH_CONFIG), 32'h0);
    // Power-down and recovery; the neighbour keeps driving.
    wr(ca(0, OFF_TX_CONFIG), 32'h60); cyc(3);
    check(32'({line_tip_oe[0], line_ring_oe[0], tx_multifunction_oe[0], line_tip_oe[1]}), 32'h1);
    check(32'({line_tip_out[0], line_ring_out[0]}), 32'h0);
    wr(ca(0, OFF_TX_CONFIG), 32'h40); cyc(5);
    check(32'(line_tip_oe[0]), 32'h0);
    cyc(25);
    check(32'(line_tip_oe[0]), 32'h1);
    c0 = line_tip_out[0]; cyc(1);
    check(32'(line_tip_out[0] ^ c0[0]), 32'h1);
    // Channel soft reset, then global soft reset.
    wr(ca(2, OFF_TX_CONFIG), 32'h48);
    wr(ca(2, OFF_CH_CONFIG), 32'h2); cyc(4);
    rd(ca(2, OFF_TX_CONFIG)); check(q, 32'h40);
    rd(ca(2, OFF_CH_CONFIG)); check(q, 32'h0);
    wr(ca(0, OFF_TX_CONFIG), 32'h48);
    wr(ADDR_GLB_RST, 32'h1); cyc(4);
    rd(ca(0, OFF_TX_CONFIG)); check(q, 32'h40);
    cyc(10);
    check(32'(line_tip_oe), 32'hf);
    // Master clock loss.
    mclk_run <= 1'b0; cyc(70);
    check(32'(line_tip_oe | line_ring_oe), 32'h0);
    rd(ADDR_GLB_STAT); check(q & 32'h1, 32'h1);
    mclk_run <= 1'b1; cyc(10);
    check(32'(line_tip_oe), 32'hf);
    // Reference pulse rate in both line rates.
    c0 = refcnt; cyc(10000);
    check(32'((refcnt - c0) inside {[154:155]}), 32'h1);
    wr(ADDR_GLB_CTRL, 32'h1);
    c0 = refcnt; cyc(10000);
    check(32'((refcnt - c0) inside {[204:205]}), 32'h1);
    wr(ADDR_GLB_CTRL, 32'h0);
    // Transmit clock loss on one channel, then the loopback exemption.
    tclk_run <= 4'h7; cyc(4400);
    check(32'(line_tip_oe), 32'h7);
    rd(ca(3, OFF_STATUS)); check(q & 32'h2, 32'h2);
    wr(ADDR_GLB_CTRL, 32'h8); cyc(10);
    check(32'(line_tip_oe[3]), 32'h1);
    summarize();
  end
endmodule // test_tx_line_driver_control
`default_nettype wire
